// File: verilog/bssp_pkg.sv
// Package with register map, field layout and timing constants of the serial port.
package bssp_pkg;
  localparam logic [11:0] BSSP_CTRL1_OFS = 12'h000;
  localparam logic [11:0] BSSP_CTRL2_OFS = 12'h004;
  localparam logic [11:0] BSSP_STAT_OFS = 12'h008;
  localparam logic [11:0] BSSP_BUF_OFS = 12'h020;
  localparam int BSSP_CLK_LSB = 0;
  localparam int BSSP_MODE_LSB = 3;
  localparam int BSSP_ABORT_BIT = 6;
  localparam int BSSP_START_BIT = 7;
  localparam int BSSP_ACT_BIT = 7;
  localparam int BSSP_SHIFT_BIT = 6;
  localparam logic [2:0] BSSP_MODE_TX8 = 3'h0;
  localparam logic [2:0] BSSP_MODE_TX4 = 3'h2;
  localparam logic [2:0] BSSP_MODE_TRX8 = 3'h4;
  localparam logic [2:0] BSSP_MODE_RX8 = 3'h5;
  localparam logic [2:0] BSSP_MODE_RX4 = 3'h6;
  localparam logic [2:0] BSSP_CLK_EXT = 3'h7;
  localparam int BSSP_HALF_SLOW = 4096;
  localparam int BSSP_HALF_MID = 128;
  localparam int BSSP_HALF_GEAR3 = 32;
  localparam int BSSP_HALF_GEAR2 = 16;
  localparam logic [7:0] BSSP_CTRL1_RST = 8'h00;
  localparam logic [1:0] BSSP_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSSP_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    BSSP_IDLE = 2'b00,
    BSSP_RUN = 2'b01,
    BSSP_WAIT = 2'b11,
    BSSP_END = 2'b10
  } bssp_state_e;
endpackage : bssp_pkg

// File: verilog/bssp_top.sv
// Buffered synchronous serial port with AXI4-Lite register access.
// Behaviour
// - Serial clock source comes from control one bits 2..0.
// - Internal clock offers four rates, drives pin, pin high when transfer starts.
// - Internal clock stops while software lags buffer servicing.
// - Outgoing bits change on falling clock pin edge.
// - Incoming bits sampled on rising clock pin edge.
// - Four-bit words use low nibble; received upper nibble is zero.
// - Words move least significant bit first.
// - Up to eight words per block, then one block-done interrupt.
// - Mode field at control one bits 5..3.
// - Transmit loads next word after last bit; block end raises interrupt.
// - Internal transmit waits after block until any buffer write or read.
// - Data out holds previous final bit until next falling edge.
// - Abort ends transfer at once, clearing active status bit 7.
// - Receive stores each word; block end raises buffer-full interrupt.
// - Internal receive waits until any buffer location is read or written.
// - External receive with unread data stores nothing and stops.
// - Clearing start stores current word, ends after its last bit.
// - Switching mode discards buffer contents.
// - Mode codes 000,010,100,101,110 select tx8,tx4,trx8,rx8,rx4.
// - Clock codes 000 slowest, 001 fc/256, 010/011 gear taps, 111 external.
// - Word count field holds words minus one.
// - Status shows active and shift-in-progress flags.
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module bssp_top #(
  parameter int HALF_SLOW = bssp_pkg::BSSP_HALF_SLOW
) (
  // System.
  input wire logic sys_clk,
  input wire logic rst_n,
  // AXI4-Lite slave.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial link.
  input wire logic clock_port_pin_i,
  output logic clock_port_pin_o,
  output logic clock_port_pin_oe,
  output logic ser_out,
  input wire logic ser_in,
  // Event.
  output logic block_done_irq
);
  import bssp_pkg::*;

  initial begin
    if (HALF_SLOW < 2 || HALF_SLOW > 8192) begin
      $error("HALF_SLOW must lie between 2 and 8192.");
    end
  end

  // Registers.
  logic [2:0] clk_sel_reg;
  logic [2:0] xfer_mode_field;
  logic start_flag;
  logic [2:0] count_reg;
  logic [7:0] data_buffer_ram [8];
  logic [7:0] shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] word_idx_reg;
  logic [12:0] div_reg;
  logic sck_reg;
  logic sck_in_d_reg;
  logic so_reg;
  logic shift_active_flag;
  logic stopping_reg;
  logic irq_reg;
  bssp_state_e state_reg;

  // AXI write path: address and data latched independently.
  logic aw_hold_reg, w_hold_reg;
  logic [11:0] aw_addr_reg;
  logic [7:0] w_data_reg;
  logic w_strb0_reg;
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  wire wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  wire wr_ok = wr_fire && w_strb0_reg;
  wire wr_ctrl1 = wr_ok && aw_addr_reg == BSSP_CTRL1_OFS;
  wire wr_ctrl2 = wr_ok && aw_addr_reg == BSSP_CTRL2_OFS;
  wire wr_buf = wr_ok && aw_addr_reg[11:5] == BSSP_BUF_OFS[11:5] && aw_addr_reg[1:0] == 2'h0;
  wire [2:0] wr_idx = aw_addr_reg[4:2];
  wire wr_map = aw_addr_reg == BSSP_CTRL1_OFS || aw_addr_reg == BSSP_CTRL2_OFS
    || (aw_addr_reg[11:5] == BSSP_BUF_OFS[11:5] && aw_addr_reg[1:0] == 2'h0);
  wire [2:0] new_mode = w_data_reg[BSSP_MODE_LSB +: 3];
  wire new_start = w_data_reg[BSSP_START_BIT];
  wire abort_req = wr_ctrl1 && w_data_reg[BSSP_ABORT_BIT];

  // AXI read path.
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_buf = rd_fire && s_axi_araddr[11:5] == BSSP_BUF_OFS[11:5]
    && s_axi_araddr[1:0] == 2'h0;
  wire rd_stat = s_axi_araddr == BSSP_STAT_OFS;
  wire rd_ctrl2 = s_axi_araddr == BSSP_CTRL2_OFS;
  wire [7:0] status_byte = {state_reg != BSSP_IDLE, shift_active_flag, 6'h00};
  wire [7:0] buf_rd = data_buffer_ram[s_axi_araddr[4:2]];
  wire rd_map = rd_stat || rd_ctrl2 || s_axi_araddr == BSSP_CTRL1_OFS
    || (s_axi_araddr[11:5] == BSSP_BUF_OFS[11:5] && s_axi_araddr[1:0] == 2'h0);
  wire [7:0] rd_val = rd_stat ? status_byte : rd_ctrl2 ? {5'h00, count_reg}
    : (s_axi_araddr[11:5] == BSSP_BUF_OFS[11:5]) ? buf_rd : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 8'h00;
      w_strb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BSSP_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= BSSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? BSSP_RESP_OKAY : BSSP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_map ? BSSP_RESP_OKAY : BSSP_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Mode decode.
  wire ext_clk = clk_sel_reg == BSSP_CLK_EXT;
  wire mode_tx = xfer_mode_field == BSSP_MODE_TX8 || xfer_mode_field == BSSP_MODE_TX4
    || xfer_mode_field == BSSP_MODE_TRX8;
  wire mode_rx = xfer_mode_field == BSSP_MODE_RX8 || xfer_mode_field == BSSP_MODE_RX4
    || xfer_mode_field == BSSP_MODE_TRX8;
  wire nibble = xfer_mode_field == BSSP_MODE_TX4 || xfer_mode_field == BSSP_MODE_RX4;
  wire [3:0] last_bit = nibble ? 4'h3 : 4'h7;
  logic [12:0] half_cnt;
  always_comb begin
    case (clk_sel_reg)
      3'h0: half_cnt = 13'(HALF_SLOW - 1);
      3'h1: half_cnt = 13'(BSSP_HALF_MID - 1);
      3'h2: half_cnt = 13'(BSSP_HALF_GEAR3 - 1);
      3'h3: half_cnt = 13'(BSSP_HALF_GEAR2 - 1);
      default: half_cnt = 13'(BSSP_HALF_MID - 1);
    endcase
  end

  // Serial clock edges: internal divider or external pin.
  wire div_tick = state_reg == BSSP_RUN && !ext_clk && div_reg == half_cnt;
  wire fall_int = div_tick && sck_reg;
  wire rise_int = div_tick && !sck_reg;
  wire fall_ext = ext_clk && sck_in_d_reg && !clock_port_pin_i;
  wire rise_ext = ext_clk && !sck_in_d_reg && clock_port_pin_i;
  wire fall_e = (fall_int || fall_ext) && state_reg == BSSP_RUN;
  wire rise_e = (rise_int || rise_ext) && state_reg == BSSP_RUN;
  wire word_end = rise_e && bit_cnt_reg == last_bit;
  wire block_end = word_end && word_idx_reg == count_reg;
  wire [7:0] rx_word = {ser_in, shift_reg[7:1]};
  wire [7:0] rx_store = nibble ? {4'h0, rx_word[7:4]} : rx_word;
  wire [2:0] next_idx = block_end ? 3'h0 : word_idx_reg + 3'h1;
  wire [7:0] tx_next = data_buffer_ram[next_idx];
  wire svc = wr_buf || rd_buf;
  wire mode_change = wr_ctrl1 && new_mode != xfer_mode_field;

  assign clock_port_pin_o = sck_reg;
  assign clock_port_pin_oe = !ext_clk;
  assign ser_out = so_reg;
  assign block_done_irq = irq_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_reg <= BSSP_CTRL1_RST[2:0];
      xfer_mode_field <= BSSP_CTRL1_RST[5:3];
      start_flag <= 1'b0;
      count_reg <= 3'h0;
      sck_in_d_reg <= 1'b1;
    end else begin
      sck_in_d_reg <= clock_port_pin_i;
      if (wr_ctrl1) begin
        clk_sel_reg <= w_data_reg[BSSP_CLK_LSB +: 3];
        xfer_mode_field <= new_mode;
        start_flag <= new_start && !w_data_reg[BSSP_ABORT_BIT];
      end else if (state_reg == BSSP_IDLE) begin
        start_flag <= 1'b0;
      end
      if (wr_ctrl2) begin
        count_reg <= w_data_reg[2:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        data_buffer_ram[i] <= 8'h00;
      end
    end else if (mode_change) begin
      for (int i = 0; i < 8; i++) begin
        data_buffer_ram[i] <= 8'h00;
      end
    end else if (wr_buf) begin
      data_buffer_ram[wr_idx] <= w_data_reg;
    end else if (mode_rx && word_end && (!ext_clk || !stopping_reg || stopping_reg)) begin
      data_buffer_ram[word_idx_reg] <= rx_store;
    end
  end

  // Transfer engine.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BSSP_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      word_idx_reg <= 3'h0;
      div_reg <= 13'h0000;
      sck_reg <= 1'b1;
      so_reg <= 1'b1;
      shift_active_flag <= 1'b0;
      stopping_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      div_reg <= (div_tick || state_reg != BSSP_RUN) ? 13'h0000 : div_reg + 13'h0001;
      if (div_tick) begin
        sck_reg <= !sck_reg;
      end
      if (fall_e) begin
        so_reg <= shift_reg[0];
        shift_active_flag <= 1'b1;
      end
      if (rise_e) begin
        shift_reg <= rx_word;
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (wr_ctrl1 && !new_start && state_reg != BSSP_IDLE) begin
        stopping_reg <= 1'b1;
      end
      case (state_reg)
        BSSP_IDLE: begin
          sck_reg <= 1'b1;
          stopping_reg <= 1'b0;
          if (start_flag && !wr_ctrl1) begin
            state_reg <= BSSP_RUN;
            shift_reg <= data_buffer_ram[3'h0];
            bit_cnt_reg <= 4'h0;
            word_idx_reg <= 3'h0;
          end
        end
        BSSP_RUN: begin
          if (word_end) begin
            bit_cnt_reg <= 4'h0;
            shift_active_flag <= 1'b0;
            word_idx_reg <= next_idx;
            shift_reg <= tx_next;
            if (block_end) begin
              irq_reg <= 1'b1;
            end
            if (stopping_reg) begin
              state_reg <= BSSP_END;
            end else if (block_end && !ext_clk) begin
              state_reg <= BSSP_WAIT;
            end else if (block_end && ext_clk && mode_rx) begin
              state_reg <= BSSP_WAIT;
            end
          end
        end
        BSSP_WAIT: begin
          if (stopping_reg) begin
            state_reg <= BSSP_END;
          end else if (ext_clk && rise_ext) begin
            state_reg <= BSSP_END;
          end else if (svc) begin
            state_reg <= BSSP_RUN;
            shift_reg <= wr_buf && wr_idx == 3'h0 ? w_data_reg : data_buffer_ram[3'h0];
          end
        end
        BSSP_END: begin
          state_reg <= BSSP_IDLE;
        end
        default: state_reg <= BSSP_IDLE;
      endcase
      if (abort_req) begin
        state_reg <= BSSP_IDLE;
        shift_active_flag <= 1'b0;
        sck_reg <= 1'b1;
      end
    end
  end

  // Properties guarding the transfer engine and the buffer.
  property p_irq_pulse;
    @(posedge sys_clk) disable iff (!rst_n) block_done_irq |=> !block_done_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("Interrupt longer than one cycle.");

  property p_abort;
    @(posedge sys_clk) disable iff (!rst_n) abort_req |=> state_reg == BSSP_IDLE;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort did not end transfer.");
  property p_idle_sck;
    @(posedge sys_clk) disable iff (!rst_n) state_reg == BSSP_IDLE && !ext_clk
      |=> clock_port_pin_o;
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("Clock pin not high idle.");
  property p_so_hold;
    @(posedge sys_clk) disable iff (!rst_n) !fall_e |=> $stable(ser_out);
  endproperty
  a_so_hold: assert property (p_so_hold) else $error("Data out moved off edge.");

  property p_start_pin;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl1 && new_start && !abort_req && state_reg == BSSP_IDLE
      |-> ##2 state_reg == BSSP_RUN && clock_port_pin_o;
  endproperty
  a_start_pin: assert property (p_start_pin)
    else $error("Transfer did not start with clock pin high.");

  property p_wait_clk;
    @(posedge sys_clk) disable iff (!rst_n)
      state_reg == BSSP_WAIT |=> $stable(clock_port_pin_o);
  endproperty
  a_wait_clk: assert property (p_wait_clk)
    else $error("Clock pin moved during wait.");

  property p_mode_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      mode_change |=> data_buffer_ram[0] == 8'h00 && data_buffer_ram[7] == 8'h00;
  endproperty
  a_mode_clear: assert property (p_mode_clear)
    else $error("Buffer kept after mode switch.");

  property p_rx_nibble;
    @(posedge sys_clk) disable iff (!rst_n)
      mode_rx && nibble && word_end && !wr_buf && !mode_change
      |=> data_buffer_ram[$past(word_idx_reg)][7:4] == 4'h0;
  endproperty
  a_rx_nibble: assert property (p_rx_nibble)
    else $error("Received nibble left upper bits set.");

  // Cover points for the main scenarios.
  c_block: cover property (@(posedge sys_clk) block_done_irq);
  c_nibble_rx: cover property (@(posedge sys_clk) mode_rx && nibble && word_end);
  c_wait: cover property (@(posedge sys_clk) state_reg == BSSP_WAIT);
  c_abort: cover property (@(posedge sys_clk) abort_req && state_reg == BSSP_RUN);
endmodule : bssp_top

// File: bench/bssp_peer_model.sv
// Behavioural model of the external serial peer that shares the serial clock.
`timescale 1ns/1ps
module bssp_peer_model (
  // Bench control.
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic [7:0] tx_pat,
  // Serial link.
  input wire logic sck,
  input wire logic sdo,
  output logic sdi,
  output logic ext_clk,
  output logic [15:0] rx_sr,
  output logic [5:0] rx_cnt
);
  logic sck_q;
  logic [7:0] tx_sr;
  initial begin
    sck_q = 1'b1;
    sdi = 1'b1;
    ext_clk = 1'b1;
    rx_sr = 16'h0000;
    rx_cnt = 6'h00;
    tx_sr = 8'h00;
  end
  // The peer changes its data after a falling pin edge and captures on a rising one.
  // Spent bits are refilled inverted so a stale line never looks valid.
  always @(posedge sys_clk) begin
    sck_q <= sck;
    if (clr) begin
      tx_sr <= tx_pat;
      rx_sr <= 16'h0000;
      rx_cnt <= 6'h00;
    end else if (sck_q && !sck) begin
      sdi <= tx_sr[0];
      tx_sr <= {~tx_sr[0], tx_sr[7:1]};
    end else if (!sck_q && sck) begin
      rx_sr <= {sdo, rx_sr[15:1]};
      rx_cnt <= rx_cnt + 6'h01;
    end
  end
  // The clock idles high between frames; each level lasts half sys clocks.
  task automatic run_clock(input int bits, input int half);
    repeat (bits) begin
      repeat (half) @(posedge sys_clk);
      ext_clk <= 1'b0;
      repeat (half) @(posedge sys_clk);
      ext_clk <= 1'b1;
    end
  endtask : run_clock
endmodule : bssp_peer_model

// File: bench/bssp_tb_top.sv
// Self-checking bench for the buffered serial port.
`timescale 1ns/1ps
module bssp_tb_top;
  import bssp_pkg::*;
  logic sys_clk, rst_n, clr, peer_clk;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic clock_port_pin_i, clock_port_pin_o, clock_port_pin_oe, ser_out, ser_in, block_done_irq;
  logic [7:0] tx_pat;
  logic [15:0] rx_sr;
  logic [5:0] rx_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  // The pin carries the port's clock while the port drives it, otherwise the peer's clock.
  assign clock_port_pin_i = clock_port_pin_oe ? clock_port_pin_o : peer_clk;
  bssp_top #(.HALF_SLOW(8)) DUT (.sys_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .clock_port_pin_i,
    .clock_port_pin_o, .clock_port_pin_oe, .ser_out, .ser_in, .block_done_irq);
  bssp_peer_model peer (.sys_clk, .clr, .tx_pat, .sck(clock_port_pin_i), .sdo(ser_out),
    .sdi(ser_in), .ext_clk(peer_clk), .rx_sr, .rx_cnt);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check(32'(s_axi_bresp), 32'(BSSP_RESP_OKAY));
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_write
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : axi_read
  function automatic logic [31:0] ctl(logic st, logic ab, logic [2:0] m, logic [2:0] s);
    return {24'h0, st, ab, m, s};
  endfunction : ctl
  // Stops the port while setting mode and clock, then sets the word count.
  task automatic cfg(input logic [2:0] m, input logic [2:0] s, input logic [2:0] n);
    axi_write(BSSP_CTRL1_OFS, ctl(1'b0, 1'b1, m, s));
    axi_write(BSSP_CTRL2_OFS, {29'h0, n});
  endtask : cfg
  task automatic pulse_clr(input logic [7:0] p);
    tx_pat <= p;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
  endtask : pulse_clr
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (block_done_irq !== 1'b1 && n < 8000);
    check(32'(n < 8000), 32'h1);
  endtask : wait_irq
  // One word in one mode; transmit results come from the peer, receive results from the buffer.
  // Receive modes preload the inverse of the peer's word so that a lost word shows.
  task automatic one_word(input logic [2:0] m, input logic [2:0] s, input logic [7:0] d,
      input logic [15:0] exp);
    cfg(m, s, 3'h0);
    axi_write(BSSP_BUF_OFS, {24'h0, m[2] ? ~d : d});
    pulse_clr(d);
    axi_write(BSSP_CTRL1_OFS, ctl(1'b1, 1'b0, m, s));
    check(32'(clock_port_pin_oe), 32'(s != BSSP_CLK_EXT));
    fork
      if (s == BSSP_CLK_EXT) peer.run_clock(8, 8);
      wait_irq();
    join
    repeat (300) @(posedge sys_clk);
    if (m[2]) axi_read(BSSP_BUF_OFS, rd, rr);
    else rd = {16'h0, rx_sr};
    check(rd, {16'h0, exp});
    axi_write(BSSP_CTRL1_OFS, ctl(1'b0, 1'b1, m, s));
    $display("case mode=%h clock=%h done", m, s);
  endtask : one_word
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, clr} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_pat} = '0;
    s_axi_wstrb = 4'h1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axi_read(BSSP_STAT_OFS, rd, rr);
    check(rd & 32'hc0, 32'h0);
    axi_read(12'h100, rd, rr);
    check(rd, 32'h0);
    check({30'h0, rr}, {30'h0, BSSP_RESP_SLVERR});
    $display("register access done");
    cfg(BSSP_MODE_TX8, 3'h3, 3'h1);
    axi_write(BSSP_BUF_OFS, 32'ha5);
    axi_write(BSSP_BUF_OFS + 12'h4, 32'h3c);
    pulse_clr(8'h00);
    axi_write(BSSP_CTRL1_OFS, ctl(1'b1, 1'b0, BSSP_MODE_TX8, 3'h3));
    check(32'(clock_port_pin_o), 32'h1);
    wait_irq();
    repeat (300) @(posedge sys_clk);
    check({rx_cnt, rx_sr}, {6'd16, 16'h3ca5});
    axi_read(BSSP_STAT_OFS, rd, rr);
    check(rd & 32'h80, 32'h80);
    axi_write(BSSP_BUF_OFS + 12'h1c, 32'h00);
    repeat (100) @(posedge sys_clk);
    check(32'(rx_cnt > 6'd16), 32'h1);
    axi_write(BSSP_CTRL1_OFS, ctl(1'b0, 1'b1, BSSP_MODE_TX8, 3'h3));
    axi_read(BSSP_STAT_OFS, rd, rr);
    check(rd & 32'h80, 32'h0);
    $display("two word transmit done");
    one_word(BSSP_MODE_RX8, 3'h0, 8'h5a, 16'h005a);
    one_word(BSSP_MODE_RX4, 3'h2, 8'hf6, 16'h0006);
    one_word(BSSP_MODE_TX4, 3'h1, 8'h9c, 16'hc000);
    one_word(BSSP_MODE_TX8, 3'h3, 8'h81, 16'h8100);
    one_word(BSSP_MODE_RX8, BSSP_CLK_EXT, 8'hc3, 16'h00c3);
    one_word(BSSP_MODE_TX8, BSSP_CLK_EXT, 8'h42, 16'h4200);
    one_word(BSSP_MODE_TRX8, 3'h3, 8'he7, 16'h00e7);
    axi_write(BSSP_BUF_OFS, 32'h55);
    cfg(BSSP_MODE_TX8, 3'h3, 3'h0);
    axi_read(BSSP_BUF_OFS, rd, rr);
    check(rd, 32'h0);
    $display("mode switch done");
    conclude();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
endmodule : bssp_tb_top
